// ### src/mmc_top.sv
// Functional notes
// [R1] mode pin latched into mode bit at reset
// [R2] only allowed mode changes; bad try locks
// [R3] mode writes ignored while secured
// [R4] direct page: free in special, once normal
// [R5] direct access uses base as bits 15:8
// [R6] page index maps flash into 8000-bfff
// [R7] page index resets to 0e, always rw
// [R8] fixed pages 0c, 0d, 0f for unpaged
// [R9] far call/return writes page index
// [R10] global address is page plus 14-bit offset
// [R11] debug resources only in debug cycles
// [R12] debug active shows debug at ff00, hides others
// [R13] debug also at bf00 when page is 0f
// [R14] normal mode runs application, no external bus
// [R15] special mode hands control to debug
// [R16] debug master uses same expansion scheme
// [R17] debug page used only when enabled, in commands
// [R18] software keeps vectors in unpaged top block
// [R19] cpu unimplemented access resets; debug allowed
// [R20] cpu wins, debug wins after 129 stalls
// [R21] unimplemented bits read zero, ignore writes
`timescale 1ns/1ps
module mmc_top #(
    parameter int ADDR_W = 12,
    parameter logic [18:0] RAM_SIZE = 19'h02000,
    parameter logic [18:0] FLASH_SIZE = 19'h20000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_pin,
    input wire logic secured,
    input wire logic dbg_active,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic call_we,
    input wire logic [3:0] call_page,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic cpu_direct,
    input wire logic cpu_fw,
    input wire logic cpu_busy,
    input wire logic [15:0] cpu_addr,
    input wire logic dbg_req,
    input wire logic dbg_we,
    input wire logic dbg_hw,
    input wire logic [15:0] dbg_addr,
    output mmc_pkg::mmc_tgt_t tgt,
    output logic cpu_stall,
    output logic dbg_stall,
    output logic illegal_reset,
    output logic [3:0] page_index_bits,
    output logic mode_select_bit,
    output logic normal_single_chip,
    output logic special_debug
);
    // register state
    logic mode_lock; // set by a refused mode change
    logic [7:0] direct_page_index; // direct page base
    logic direct_written; // first normal-mode write seen
    logic [3:0] debug_program_page_register;
    logic dpage_en; // debug page expansion enable
    logic [7:0] starve; // debug wait counter
    logic [15:0] tgt_local; // local address of last target
    // axi write holding
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    logic next_mode;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // write decode
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_hit;
    logic wr_ok;
    always_comb begin
        wr_fire = aw_held && w_held && !s_axi_bvalid;
        wr_idx = aw_addr[9:2];
        wr_hit = (aw_addr[1:0] == 2'h0) &&
            (aw_addr[ADDR_W-1:10] == '0) &&
            (wr_idx == mmc_pkg::IDX_MODE ||
             wr_idx == mmc_pkg::IDX_DIRECT ||
             wr_idx == mmc_pkg::IDX_PAGE ||
             wr_idx == mmc_pkg::IDX_DPAGE ||
             wr_idx == mmc_pkg::IDX_STAT);
        wr_ok = wr_fire && wr_hit && w_lane0;
    end

    // mode select next value
    logic mode_wr;
    logic mode_new;
    logic mode_allowed;
    always_comb begin
        mode_wr = wr_ok && wr_idx == mmc_pkg::IDX_MODE;
        mode_new = w_data[mmc_pkg::MODE_BIT];
        // special may go to normal, never back
        mode_allowed = (mode_new == mode_select_bit) ||
            (mode_select_bit == mmc_pkg::MODE_SPECIAL); // R2
        next_mode = mode_select_bit;
        if (rst) begin
            next_mode = mode_pin; // R1
        end else if (mode_wr && !secured) begin // R3
            if (mode_allowed && !mode_lock) begin // R2
                next_mode = mode_new;
            end
        end
    end

    // mode bit and mode decodes
    always_ff @(posedge clk) begin
        mode_select_bit <= next_mode; // R1
        // application mode, no external bus port
        normal_single_chip <=
            next_mode == mmc_pkg::MODE_NORMAL; // R14
        // special mode asks debug to take the cpu
        special_debug <=
            next_mode == mmc_pkg::MODE_SPECIAL; // R15
    end

    // lock after a refused change in normal mode
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_lock <= 1'b0;
        end else if (mode_wr && !secured && !mode_allowed) begin
            mode_lock <= 1'b1; // R2
        end
    end

    // direct page base, write once in normal mode
    always_ff @(posedge clk) begin
        if (rst) begin
            direct_page_index <= 8'h00;
            direct_written <= 1'b0;
        end else if (wr_ok && wr_idx == mmc_pkg::IDX_DIRECT) begin
            if (mode_select_bit == mmc_pkg::MODE_SPECIAL) begin
                direct_page_index <= w_data[7:0]; // R4
            end else if (!direct_written) begin
                direct_page_index <= w_data[7:0]; // R4
                direct_written <= 1'b1;
            end
        end
    end

    // page index, far call path wins over bus
    always_ff @(posedge clk) begin
        if (rst) begin
            page_index_bits <= mmc_pkg::PAGE_RST; // R7
        end else if (call_we) begin
            page_index_bits <= call_page; // R9
        end else if (wr_ok && wr_idx == mmc_pkg::IDX_PAGE) begin
            page_index_bits <= w_data[3:0]; // R7 R21
        end
    end

    // debug page register and its enable
    always_ff @(posedge clk) begin
        if (rst) begin
            debug_program_page_register <= mmc_pkg::PAGE_RST;
            dpage_en <= 1'b0;
        end else if (wr_ok && wr_idx == mmc_pkg::IDX_DPAGE) begin
            debug_program_page_register <= w_data[3:0]; // R16
            dpage_en <= w_data[mmc_pkg::DPAGE_EN_BIT]; // R17
        end
    end

    // axi write channels
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mmc_pkg::RESP_OKAY;
        end else begin
            // ready a cycle after valid shows, while idle
            s_axi_awready <= !aw_held && s_axi_awvalid;
            s_axi_wready <= !w_held && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? mmc_pkg::RESP_OKAY
                                      : mmc_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // read mux, unimplemented bits zero
    logic [7:0] rd_idx;
    logic rd_map;
    logic [31:0] rd_val;
    always_comb begin
        rd_idx = s_axi_araddr[9:2];
        rd_map = (s_axi_araddr[1:0] == 2'h0) &&
            (s_axi_araddr[ADDR_W-1:10] == '0);
        rd_val = 32'h0;
        unique case (rd_idx)
            mmc_pkg::IDX_MODE: begin
                rd_val[mmc_pkg::MODE_BIT] = mode_select_bit; // R21
            end
            mmc_pkg::IDX_DIRECT: begin
                rd_val[7:0] = direct_page_index; // R4
            end
            mmc_pkg::IDX_PAGE: begin
                rd_val[3:0] = page_index_bits; // R7 R21
            end
            mmc_pkg::IDX_DPAGE: begin
                rd_val[3:0] = debug_program_page_register; // R16
                rd_val[mmc_pkg::DPAGE_EN_BIT] = dpage_en;
            end
            mmc_pkg::IDX_STAT: begin
                rd_val[3:0] = {direct_written, mode_lock,
                               dbg_active, secured};
            end
            default: begin
                rd_map = 1'b0;
            end
        endcase
    end

    // axi read channel
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= mmc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_map ? rd_val : 32'h0;
                s_axi_rresp <= rd_map ? mmc_pkg::RESP_OKAY
                                      : mmc_pkg::RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // local to global expansion
    function automatic logic [17:0] to_global(
        input logic [15:0] la,
        input logic [3:0] win
    );
        logic [3:0] pg;
        pg = mmc_pkg::PAGE_TOP;
        unique case (la[15:14])
            mmc_pkg::RGN_LOW: pg = mmc_pkg::PAGE_LOW; // R8
            mmc_pkg::RGN_MID: pg = mmc_pkg::PAGE_MID; // R8
            mmc_pkg::RGN_WIN: pg = win; // R6
            mmc_pkg::RGN_TOP: pg = mmc_pkg::PAGE_TOP; // R8
        endcase
        return {pg, la[13:0]}; // R10
    endfunction : to_global

    // arbitration between cpu and debug master
    logic starved;
    logic pick_dbg;
    logic pick_cpu;
    always_comb begin
        starved = starve > mmc_pkg::STARVE_LIMIT; // R20
        pick_dbg = dbg_req &&
            (!cpu_req || (starved && !cpu_busy)); // R20
        pick_cpu = cpu_req && !pick_dbg;
    end

    // starvation counter, saturating
    always_ff @(posedge clk) begin
        if (rst || !dbg_req || pick_dbg) begin
            starve <= 8'h00;
        end else if (starve != 8'hff) begin
            starve <= starve + 8'h01;
        end
    end

    // address build for the granted master
    logic [15:0] la;
    logic [3:0] win;
    logic [17:0] ga;
    logic [18:0] ga19;
    logic dcyc;
    logic hit;
    logic impl;
    always_comb begin
        la = dbg_addr;
        if (pick_cpu) begin
            la = cpu_addr;
            if (cpu_direct) begin
                la = {direct_page_index, cpu_addr[7:0]}; // R5
            end
        end
        // debug cycles: any debug master access or firmware
        dcyc = pick_dbg || (pick_cpu && cpu_fw); // R11
        win = page_index_bits; // R6 R16
        if (dpage_en && ((pick_cpu && cpu_fw) ||
                         (pick_dbg && dbg_hw))) begin
            win = debug_program_page_register; // R17
        end
        ga = to_global(la, win); // R10 R16
        ga19 = {1'b0, ga};
        hit = dbg_active && (la[15:8] == mmc_pkg::DBG_HI || // R12
            (la[15:8] == mmc_pkg::DBG_ALIAS &&
             page_index_bits == mmc_pkg::PAGE_ALIAS)); // R13
        impl = ga19 <= mmc_pkg::REG_TOP ||
            (ga19 >= mmc_pkg::RAM_END - RAM_SIZE &&
             ga19 <= mmc_pkg::RAM_TOP) ||
            (ga19 >= mmc_pkg::DF_LOW && ga19 <= mmc_pkg::DF_TOP) ||
            ga19 >= mmc_pkg::GLB_END - FLASH_SIZE;
    end

    // target request and stall flags
    always_ff @(posedge clk) begin
        if (rst) begin
            tgt <= '0;
            tgt_local <= 16'h0000;
            cpu_stall <= 1'b0;
            dbg_stall <= 1'b0;
            illegal_reset <= 1'b0;
        end else begin
            cpu_stall <= cpu_req && !pick_cpu; // R20
            dbg_stall <= dbg_req && !pick_dbg; // R20
            tgt_local <= la;
            tgt.write <= pick_cpu ? cpu_we : dbg_we;
            tgt.from_dbg <= pick_dbg;
            tgt.dbg_cycle <= dcyc;
            tgt.gaddr <= ga;
            tgt.dbg_sel <= hit && dcyc; // R11 R12
            tgt.other_sel <= !hit && impl; // R12
            tgt.unimpl <= !impl && !(hit && dcyc);
            // cpu outside firmware into a hole: reset
            illegal_reset <= pick_cpu && !cpu_fw &&
                !impl && !hit; // R19
            tgt.valid <= pick_dbg || (pick_cpu &&
                (cpu_fw || impl || hit)); // R19
        end
    end

    // assertions
    sequence s_dbg_starved;
        dbg_req && cpu_req && starved && !cpu_busy;
    endsequence
    sequence s_dbg_served;
        tgt.valid && tgt.from_dbg && !dbg_stall;
    endsequence
    // reset checks must not be switched off by reset itself
    a_mode_reset_capture: assert property ( // R1
        @(posedge clk) disable iff (1'b0)
        rst |=> mode_select_bit == $past(mode_pin))
        else $error("mode bit not taken from pin");
    a_mode_stays_normal: assert property ( // R2
        mode_select_bit == mmc_pkg::MODE_NORMAL && !rst
        |=> mode_select_bit == mmc_pkg::MODE_NORMAL)
        else $error("mode left normal");
    a_secured_mode_block: assert property ( // R3
        mode_wr && secured |=> $stable(mode_select_bit))
        else $error("mode written while secured");
    a_direct_write_once: assert property ( // R4
        direct_written && normal_single_chip
        |=> $stable(direct_page_index))
        else $error("direct base changed twice");
    a_page_reset_value: assert property ( // R7
        @(posedge clk) disable iff (1'b0)
        rst |=> page_index_bits == mmc_pkg::PAGE_RST)
        else $error("page index reset wrong");
    a_call_page_write: assert property ( // R9
        call_we |=> page_index_bits == $past(call_page))
        else $error("far call page not written");
    a_top_fixed_page: assert property ( // R8
        tgt.valid && tgt_local[15:14] == mmc_pkg::RGN_TOP
        |-> tgt.gaddr[17:14] == mmc_pkg::PAGE_TOP)
        else $error("top block not on page 0f");
    a_offset_kept: assert property ( // R10
        tgt.valid |-> tgt.gaddr[13:0] == tgt_local[13:0])
        else $error("offset not carried");
    a_dbg_only_cycle: assert property ( // R11
        tgt.dbg_sel |-> tgt.dbg_cycle && !tgt.other_sel)
        else $error("debug select outside debug cycle");
    a_starve_grant: assert property ( // R20
        s_dbg_starved |=> s_dbg_served)
        else $error("starved debug not granted");
    a_cpu_priority: assert property ( // R20
        cpu_req && dbg_req && !starved |=> dbg_stall && !cpu_stall)
        else $error("cpu lost arbitration");
    a_illegal_cpu: assert property ( // R19
        illegal_reset |-> !tgt.valid)
        else $error("illegal access reached target");
endmodule : mmc_top

// ### src/mmc_pkg.sv
package mmc_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_MODE = 8'h0b;
    localparam logic [7:0] IDX_DIRECT = 8'h11;
    localparam logic [7:0] IDX_PAGE = 8'h30;
    localparam logic [7:0] IDX_DPAGE = 8'h31;
    localparam logic [7:0] IDX_STAT = 8'h32;
    // field positions
    localparam int MODE_BIT = 7;
    localparam int DPAGE_EN_BIT = 7;
    // mode select bit encodings
    localparam logic MODE_NORMAL = 1'b1;
    localparam logic MODE_SPECIAL = 1'b0;
    // page numbers
    localparam logic [3:0] PAGE_RST = 4'he;
    localparam logic [3:0] PAGE_LOW = 4'hc;
    localparam logic [3:0] PAGE_MID = 4'hd;
    localparam logic [3:0] PAGE_TOP = 4'hf;
    localparam logic [3:0] PAGE_ALIAS = 4'hf;
    // local address[15:14] region codes
    localparam logic [1:0] RGN_LOW = 2'h0;
    localparam logic [1:0] RGN_MID = 2'h1;
    localparam logic [1:0] RGN_WIN = 2'h2;
    localparam logic [1:0] RGN_TOP = 2'h3;
    // debug resource windows, local address[15:8]
    localparam logic [7:0] DBG_HI = 8'hff;
    localparam logic [7:0] DBG_ALIAS = 8'hbf;
    // arbiter starvation threshold in cycles
    localparam logic [7:0] STARVE_LIMIT = 8'h80;
    // implemented global resources
    localparam logic [18:0] REG_TOP = 19'h003ff;
    localparam logic [18:0] RAM_TOP = 19'h03fff;
    localparam logic [18:0] RAM_END = 19'h04000;
    localparam logic [18:0] DF_LOW = 19'h04400;
    localparam logic [18:0] DF_TOP = 19'h053ff;
    localparam logic [18:0] GLB_END = 19'h40000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // target bus request
    typedef struct packed {
        logic valid;
        logic write;
        logic from_dbg;
        logic dbg_cycle;
        logic dbg_sel;
        logic other_sel;
        logic unimpl;
        logic [17:0] gaddr;
    } mmc_tgt_t;
endpackage : mmc_pkg

// ### bench/mmc_dbg_master.sv
`timescale 1ns/1ps
// debug master model, holds its request until the grant lands
module mmc_dbg_master (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [15:0] addr,
    input wire logic hw,
    input wire mmc_pkg::mmc_tgt_t tgt,
    input wire logic dbg_stall,
    output logic dbg_req,
    output logic [15:0] dbg_addr,
    output logic dbg_hw,
    output int waits
);
    logic pend; // request outstanding
    logic done; // our grant is showing on the target port
    assign done = tgt.valid && tgt.from_dbg;
    // drop in the grant cycle so one access is taken once
    assign dbg_req = pend && !done;
    // released payload shows the inverse, not the last value
    assign dbg_addr = pend ? addr : ~addr;
    assign dbg_hw = pend ? hw : ~hw;
    // outstanding flag
    always_ff @(posedge clk) begin
        if (rst) begin
            pend <= 1'b0;
        end else if (go) begin
            pend <= 1'b1;
        end else if (done) begin
            pend <= 1'b0;
        end
    end
    // stalled request count, for the starvation check
    always_ff @(posedge clk) begin
        if (rst || go) begin
            waits <= 0;
        end else if (pend && dbg_stall) begin
            waits <= waits + 1;
        end
    end
endmodule : mmc_dbg_master

// ### bench/mmc_top_tb.sv
`timescale 1ns/1ps
module mmc_top_tb;
    logic clk, rst, mode_pin, secured, dbg_active;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic call_we, cpu_req, cpu_direct, cpu_fw, dbg_req, dbg_hw;
    logic [3:0] call_page, page_index_bits;
    logic [15:0] cpu_addr, dbg_addr, daddr;
    logic cpu_stall, dbg_stall, illegal_reset, mode_select_bit, cpu_busy;
    logic normal_single_chip, special_debug, dgo, dhw;
    mmc_pkg::mmc_tgt_t tgt;
    int waits;
    int num_errors = 0; // mismatches
    int compares = 0; // comparisons made
    // block under test, write strobe and write enables tied
    mmc_top DUT (.clk, .rst, .mode_pin, .secured, .dbg_active,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .call_we, .call_page, .cpu_req, .cpu_we(1'b0),
        .cpu_direct, .cpu_fw, .cpu_busy, .cpu_addr, .dbg_req,
        .dbg_we(1'b0), .dbg_hw, .dbg_addr, .tgt, .cpu_stall, .dbg_stall,
        .illegal_reset, .page_index_bits, .mode_select_bit,
        .normal_single_chip, .special_debug);
    // far side debug master
    mmc_dbg_master PARTNER (.clk, .rst, .go(dgo), .addr(daddr),
        .hw(dhw), .tgt, .dbg_stall, .dbg_req, .dbg_addr, .dbg_hw, .waits);
    // clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // one comparison of a settled value
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // verdict and end of run
    task complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // axi-lite write, each channel released when taken
    task automatic axi_write(input logic [7:0] idx, input logic [7:0] v);
        int n;
        n = 0;
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) check(32'h1, 32'h0);
        @(posedge clk);
    endtask : axi_write
    // axi-lite read, data and response taken at the rvalid edge
    task automatic axi_read(input logic [7:0] idx, output logic [31:0] d,
            output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 50) check(32'h1, 32'h0);
        @(posedge clk);
    endtask : axi_read
    // read a register and compare
    task automatic reg_is(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(idx, d, r);
        check(d, exp);
    endtask : reg_is
    // one single-cycle cpu access, registered result sampled the cycle after
    task automatic cpu_acc(input logic [15:0] a, input logic dir,
            input logic fw, output mmc_pkg::mmc_tgt_t t, output logic ill);
        cpu_addr <= a;
        cpu_direct <= dir;
        cpu_fw <= fw;
        cpu_req <= 1'b1;
        @(posedge clk);
        cpu_req <= 1'b0;
        @(posedge clk);
        t = tgt;
        ill = illegal_reset;
    endtask : cpu_acc
    // one debug access through the partner, bounded wait for grant
    task automatic dbg_run(input logic [15:0] a, input logic hw,
            output mmc_pkg::mmc_tgt_t t);
        int n;
        n = 0;
        daddr <= a;
        dhw <= hw;
        dgo <= 1'b1;
        @(posedge clk);
        dgo <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (!(tgt.valid === 1'b1 && tgt.from_dbg === 1'b1)
            && n < 300);
        t = tgt;
        if (n >= 300) check(32'h1, 32'h0);
    endtask : dbg_run
    // reset with a chosen mode pin level
    task automatic do_reset(input logic pin);
        rst <= 1'b1;
        mode_pin <= pin;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset
    // normal mode out of reset, write-once base, refused mode change
    task automatic t_normal();
        logic [31:0] d;
        logic [1:0] r;
        check({31'h0, normal_single_chip}, 32'h1);
        reg_is(mmc_pkg::IDX_MODE, 32'h80);
        reg_is(mmc_pkg::IDX_PAGE, 32'h0e);
        axi_read(8'h40, d, r);
        check({30'h0, r}, {30'h0, mmc_pkg::RESP_SLVERR});
        axi_write(mmc_pkg::IDX_DIRECT, 8'h12);
        axi_write(mmc_pkg::IDX_DIRECT, 8'h34);
        reg_is(mmc_pkg::IDX_DIRECT, 32'h12);
        axi_write(mmc_pkg::IDX_MODE, 8'h00);
        reg_is(mmc_pkg::IDX_MODE, 32'h80);
        axi_read(mmc_pkg::IDX_STAT, d, r);
        check({31'h0, d[2]}, 32'h1);
    endtask : t_normal
    // special mode, repeated base writes, secured and allowed change
    task automatic t_special();
        do_reset(1'b0);
        check({31'h0, special_debug}, 32'h1);
        reg_is(mmc_pkg::IDX_MODE, 32'h00);
        axi_write(mmc_pkg::IDX_DIRECT, 8'h81);
        axi_write(mmc_pkg::IDX_DIRECT, 8'h80);
        reg_is(mmc_pkg::IDX_DIRECT, 32'h80);
        secured <= 1'b1;
        axi_write(mmc_pkg::IDX_MODE, 8'h80);
        reg_is(mmc_pkg::IDX_MODE, 32'h00);
        secured <= 1'b0;
        axi_write(mmc_pkg::IDX_MODE, 8'h80);
        reg_is(mmc_pkg::IDX_MODE, 32'h80);
    endtask : t_special
    // window, fixed pages, direct page and holes
    task automatic t_map();
        logic [15:0] la [4] = '{16'h0123, 16'h4123, 16'h8123, 16'hc123};
        logic [17:0] ga [4] = '{18'h30123, 18'h34123, 18'h24123,
            18'h3c123};
        mmc_pkg::mmc_tgt_t t;
        logic ill;
        axi_write(mmc_pkg::IDX_PAGE, 8'hf9);
        reg_is(mmc_pkg::IDX_PAGE, 32'h09);
        cpu_acc(16'h0034, 1'b1, 1'b0, t, ill);
        check({14'h0, t.gaddr}, 32'h24034);
        for (int i = 0; i < 4; i++) begin
            cpu_acc(la[i], 1'b0, 1'b0, t, ill);
            check({14'h0, t.gaddr}, {14'h0, ga[i]});
        end
        axi_write(mmc_pkg::IDX_PAGE, 8'h05);
        cpu_acc(16'h8123, 1'b0, 1'b0, t, ill);
        check({30'h0, ill, t.valid}, 32'h2);
        dbg_run(16'h8123, 1'b0, t);
        check({30'h0, t.valid, t.unimpl}, 32'h3);
    endtask : t_map
    // far call page write, debug windows, debug page register
    task automatic t_debug();
        mmc_pkg::mmc_tgt_t t;
        logic ill;
        call_page <= 4'hf;
        call_we <= 1'b1;
        @(posedge clk);
        call_we <= 1'b0;
        @(posedge clk);
        check({28'h0, page_index_bits}, 32'hf);
        dbg_active <= 1'b1;
        cpu_acc(16'hbf10, 1'b0, 1'b1, t, ill);
        check({30'h0, t.dbg_sel, t.other_sel}, 32'h2);
        cpu_acc(16'hff10, 1'b0, 1'b1, t, ill);
        check({30'h0, t.dbg_sel, t.other_sel}, 32'h2);
        cpu_acc(16'hff10, 1'b0, 1'b0, t, ill);
        check({30'h0, t.dbg_sel, t.other_sel}, 32'h0);
        dbg_active <= 1'b0;
        cpu_acc(16'hff10, 1'b0, 1'b1, t, ill);
        check({30'h0, t.dbg_sel, t.other_sel}, 32'h1);
        axi_write(mmc_pkg::IDX_DPAGE, 8'h8a);
        dbg_run(16'h8010, 1'b1, t);
        check({14'h0, t.gaddr}, 32'h28010);
        dbg_run(16'h8010, 1'b0, t);
        check({14'h0, t.gaddr}, 32'h3c010);
    endtask : t_debug
    // cpu holds the bus, debug takes it after its starvation limit
    task automatic t_arb();
        mmc_pkg::mmc_tgt_t t;
        cpu_addr <= 16'hc010;
        cpu_fw <= 1'b0;
        cpu_req <= 1'b1;
        dbg_run(16'hc020, 1'b0, t);
        check({31'h0, cpu_stall}, 32'h1);
        check(waits, 32'd129);
        // busy cpu finishes its operation before handing over
        cpu_busy <= 1'b1;
        fork
            dbg_run(16'hc030, 1'b0, t);
            begin
                repeat (140) @(posedge clk);
                cpu_busy <= 1'b0;
            end
        join
        check(waits, 32'd139);
        cpu_req <= 1'b0;
        @(posedge clk);
    endtask : t_arb
    // main sequence
    initial begin
        rst = 1'b1;
        mode_pin = 1'b1;
        {secured, dbg_active, call_we, cpu_req, cpu_direct, cpu_fw} = '0;
        cpu_busy = 1'b0;
        {dgo, dhw, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {call_page, cpu_addr, daddr} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_normal();
        t_special();
        t_map();
        t_debug();
        t_arb();
        complete_run();
    end
    // hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : mmc_top_tb
